// file: core/ept_defs.svh
`ifndef EPT_DEFS_SVH
`define EPT_DEFS_SVH

// version slots and layout
`define EPT_VA_SLOTS 512
`define EPT_VA_SLOT_BYTES 8
`define EPT_VA_LAST_OFS 4088
`define EPT_VA_PAGES 4
`define EPT_MAP_ENTRIES 16
// page info record field offsets
`define EPT_INFO_STATUS_OFS 0
`define EPT_INFO_FLAGS_OFS 8
`define EPT_INFO_PARENT_OFS 16
// status bits
`define EPT_ST_CHILD 0
`define EPT_ST_VCHILD 1
// flags bits
`define EPT_FL_R 0
`define EPT_FL_W 1
`define EPT_FL_X 2
`define EPT_FL_PEND 3
`define EPT_FL_MOD 4
`define EPT_FL_PR 5
`define EPT_FL_TYPE_LO 8
`define EPT_FL_TYPE_HI 15
`define EPT_FL_BLK 63
// register byte offsets
`define EPT_REG_CMD 8'h00
`define EPT_REG_ARG_IDX 8'h04
`define EPT_REG_ARG_SLOT 8'h08
`define EPT_REG_ARG_ADDR 8'h0C
`define EPT_REG_ARG_OWNER 8'h10
`define EPT_REG_ARG_FLAGS 8'h14
`define EPT_REG_RESULT 8'h18
`define EPT_REG_INFO_ST 8'h1C
`define EPT_REG_INFO_FL_LO 8'h20
`define EPT_REG_INFO_FL_HI 8'h24
`define EPT_REG_INFO_PAR 8'h28
`define EPT_REG_ACC 8'h2C
`define EPT_REG_ACC_RES 8'h30
`define EPT_REG_VIRT 8'h34
`define EPT_VER_RESET 64'h0000_0000_0000_0001
`define EPT_ZERO64 64'h0000_0000_0000_0000

`endif

// file: core/ept_pkg.sv
package ept_pkg;
    typedef enum logic [7:0] {
        PT_CONTROL = 8'h00,
        PT_THREAD = 8'h01,
        PT_REGULAR = 8'h02,
        PT_VERSION = 8'h03,
        PT_TRIMMED = 8'h04,
        SHADOW_STACK_FIRST_PAGE_PG = 8'h05,
        SHADOW_STACK_REST_PAGE_PG = 8'h06
    } ept_ptype_e;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_LOAD = 3'h1,
        CMD_EVICT = 3'h2,
        CMD_RELOAD = 3'h3,
        CMD_INFO = 3'h4
    } ept_cmd_e;

    typedef struct packed {
        logic valid;
        logic rd;
        logic wr;
        logic ex;
        ept_ptype_e ptype;
        logic [15:0] ownerId;
        logic [31:0] linAddr;
        logic blocked;
        logic pending;
        logic modified;
        logic permRestricted;
    } ept_entry_s;

    typedef struct packed {
        logic [63:0] status;
        logic [63:0] flags;
        logic [63:0] parent;
    } ept_info_s;
endpackage

// file: core/ept_version_array.sv
`timescale 1ns/100ps
`include "ept_defs.svh"

module ept_version_array
    import ept_pkg::*;
#(
    parameter int PAGES = `EPT_VA_PAGES,
    parameter int SLOTS = `EPT_VA_SLOTS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [$clog2(PAGES*SLOTS)-1:0] slotIdx,
    input wire logic wrEn,
    input wire logic [63:0] wrData,
    output logic [63:0] rdData
);
    // slot n at byte 8n of its page; last at 4088
    logic [63:0] mem [PAGES*SLOTS];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // every slot starts empty, and empty reads zero
            for (int i = 0; i < PAGES * SLOTS; i++) begin
                mem[i] <= `EPT_ZERO64;
            end
            rdData <= `EPT_ZERO64;
        end else begin
            if (wrEn) begin
                mem[slotIdx] <= wrData;
            end
            rdData <= mem[slotIdx];
        end
    end
endmodule

// file: core/ept_page_tracking.sv
`timescale 1ns/100ps
`include "ept_defs.svh"

// What this block does
// - each version page holds 512 eight-byte slots, slot n at byte 8n
// - eviction writes a unique version number into the chosen slot
// - reload needs the slot holding the version; success clears the slot
// - version pages evict too, version stored in a different version page
// - one hidden map entry per loaded protected page
// - entry keeps valid, owner, address, blocked, pending, modified, restricted
// - access granted if the entry is valid and any requested read, write or fetch has matching entry permission
// - entry page type is one of seven kinds
// - info record: status at 0, flags at 8, parent pointer at 16
// - status bit 0 child pages present, zero for non-control pages
// - status bit 1 virtual children, zero in guest mode; always zero here, VIRT feeds bit 0; 63:2 reserved
// - flags: perms 0-2, pending/modified/restricted 3-5, type 15:8, blocked 63
module ept_page_tracking
    import ept_pkg::*;
#(
    parameter int ENTRIES = `EPT_MAP_ENTRIES,
    parameter int PAGES = `EPT_VA_PAGES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int SW = $clog2(PAGES * `EPT_VA_SLOTS);
    localparam int EW = $clog2(ENTRIES);

    ////////////////////////////////////////////////////////////////////////////
    // state
    ept_entry_s map_q [ENTRIES];
    ept_entry_s map_d [ENTRIES];
    logic [63:0] verCnt_q, verCnt_d;
    logic [63:0] savedVer_q [ENTRIES];
    logic [63:0] savedVer_d [ENTRIES];
    logic [31:0] argIdx_q, argIdx_d, argSlot_q, argSlot_d;
    logic [31:0] argAddr_q, argAddr_d, argOwner_q, argOwner_d;
    logic [31:0] argFlags_q, argFlags_d, result_q, result_d;
    logic [31:0] acc_q, acc_d, accRes_q, accRes_d, rdata_q, rdata_d;
    logic virt_q, virt_d;
    ept_info_s info_q, info_d;
    logic [2:0] phase_q, phase_d;
    ept_cmd_e cmd_q, cmd_d;
    logic rdPend_q, rdPend_d;
    logic vaWr;
    logic [63:0] vaWrData, vaRd;
    logic [SW-1:0] vaIdx;

    ept_version_array #(
        .PAGES(PAGES),
        .SLOTS(`EPT_VA_SLOTS)
    ) u_va (
        .ref_clk(ref_clk),
        .rst(rst),
        .slotIdx(vaIdx),
        .wrEn(vaWr),
        .wrData(vaWrData),
        .rdData(vaRd)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [63:0] flagsOf(input ept_entry_s e);
        logic [63:0] f;
        f = `EPT_ZERO64;
        f[`EPT_FL_R] = e.rd;
        f[`EPT_FL_W] = e.wr;
        f[`EPT_FL_X] = e.ex;
        f[`EPT_FL_PEND] = e.pending;
        f[`EPT_FL_MOD] = e.modified;
        f[`EPT_FL_PR] = e.permRestricted;
        f[`EPT_FL_TYPE_HI:`EPT_FL_TYPE_LO] = e.ptype;
        f[`EPT_FL_BLK] = e.blocked;
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // command engine and bus
    logic [EW-1:0] ei;
    logic busy;
    assign ei = argIdx_q[EW-1:0];
    assign busy = (phase_q != 3'h0);
    // reads take one wait state so the registered data stands at acceptance
    assign avs_waitrequest = (avs_write && busy) || (avs_read && (busy || !rdPend_q));
    assign avs_readdata = rdata_q;

    always_comb begin
        logic childAny;
        logic slotAddrOk;
        childAny = 1'b0;
        slotAddrOk = 1'b0;
        map_d = map_q;
        savedVer_d = savedVer_q;
        verCnt_d = verCnt_q;
        {argIdx_d, argSlot_d, argAddr_d, argOwner_d} = {argIdx_q, argSlot_q, argAddr_q, argOwner_q};
        argFlags_d = argFlags_q;
        result_d = result_q;
        acc_d = acc_q;
        accRes_d = accRes_q;
        virt_d = virt_q;
        info_d = info_q;
        phase_d = phase_q;
        cmd_d = cmd_q;
        rdata_d = rdata_q;
        rdPend_d = 1'b0;
        vaWr = 1'b0;
        vaWrData = `EPT_ZERO64;
        vaIdx = argSlot_q[SW-1:0];
        case (phase_q)
            3'h0: begin
                if (avs_write && !avs_waitrequest) begin
                    case (avs_address)
                        `EPT_REG_CMD: begin
                            cmd_d = ept_cmd_e'(avs_writedata[2:0]);
                            phase_d = 3'h1;
                        end
                        `EPT_REG_ARG_IDX: argIdx_d = merge(argIdx_q, avs_writedata,
                            avs_byteenable);
                        `EPT_REG_ARG_SLOT: argSlot_d = merge(argSlot_q, avs_writedata,
                            avs_byteenable);
                        `EPT_REG_ARG_ADDR: argAddr_d = merge(argAddr_q, avs_writedata,
                            avs_byteenable);
                        `EPT_REG_ARG_OWNER: argOwner_d = merge(argOwner_q, avs_writedata,
                            avs_byteenable);
                        `EPT_REG_ARG_FLAGS: argFlags_d = merge(argFlags_q, avs_writedata,
                            avs_byteenable);
                        `EPT_REG_ACC: acc_d = merge(acc_q, avs_writedata, avs_byteenable);
                        `EPT_REG_VIRT: virt_d = avs_byteenable[0] ? avs_writedata[0] : virt_q;
                        default: ;
                    endcase
                end
                // capture in the wait state, accept on the next edge
                if (avs_read && !rdPend_q) begin
                    rdPend_d = 1'b1;
                    case (avs_address)
                        `EPT_REG_ARG_IDX: rdata_d = argIdx_q;
                        `EPT_REG_ARG_SLOT: rdata_d = argSlot_q;
                        `EPT_REG_ARG_ADDR: rdata_d = argAddr_q;
                        `EPT_REG_ARG_OWNER: rdata_d = argOwner_q;
                        `EPT_REG_ARG_FLAGS: rdata_d = argFlags_q;
                        `EPT_REG_RESULT: rdata_d = result_q;
                        `EPT_REG_INFO_ST: rdata_d = info_q.status[31:0];
                        `EPT_REG_INFO_FL_LO: rdata_d = info_q.flags[31:0];
                        `EPT_REG_INFO_FL_HI: rdata_d = info_q.flags[63:32];
                        `EPT_REG_INFO_PAR: rdata_d = info_q.parent[31:0];
                        `EPT_REG_ACC: rdata_d = acc_q;
                        `EPT_REG_ACC_RES: rdata_d = accRes_q;
                        `EPT_REG_VIRT: rdata_d = {31'h0000_0000, virt_q};
                        default: rdata_d = 32'h0000_0000;
                    endcase
                end
            end
            3'h1: begin
                // slot read returns in the next cycle
                phase_d = 3'h2;
                case (cmd_q)
                    CMD_LOAD: begin
                        map_d[ei].valid = 1'b1;
                        map_d[ei].rd = argFlags_q[`EPT_FL_R];
                        map_d[ei].wr = argFlags_q[`EPT_FL_W];
                        map_d[ei].ex = argFlags_q[`EPT_FL_X];
                        map_d[ei].pending = argFlags_q[`EPT_FL_PEND];
                        map_d[ei].modified = argFlags_q[`EPT_FL_MOD];
                        map_d[ei].permRestricted = argFlags_q[`EPT_FL_PR];
                        map_d[ei].ptype =
                            ept_ptype_e'(argFlags_q[`EPT_FL_TYPE_HI:`EPT_FL_TYPE_LO]);
                        map_d[ei].blocked = argFlags_q[31];
                        map_d[ei].ownerId = argOwner_q[15:0];
                        map_d[ei].linAddr = argAddr_q;
                        result_d = 32'h0000_0000;
                        phase_d = 3'h0;
                    end
                    CMD_INFO: begin
                        for (int i = 0; i < ENTRIES; i++) begin
                            if (map_q[i].valid && map_q[i].ownerId == argIdx_q[15:0]) begin
                                childAny = 1'b1;
                            end
                        end
                        info_d.status = `EPT_ZERO64;
                        if (map_q[ei].ptype == PT_CONTROL) begin
                            info_d.status[`EPT_ST_CHILD] = childAny | virt_q;
                            info_d.status[`EPT_ST_VCHILD] = 1'b0;
                        end
                        info_d.flags = flagsOf(map_q[ei]);
                        info_d.parent = {48'h0000_0000_0000, map_q[ei].ownerId};
                        result_d = map_q[ei].valid ? 32'h0000_0000 : 32'h0000_0001;
                        phase_d = 3'h0;
                    end
                    CMD_NONE: begin
                        // access check: bit0 read, bit1 write, bit2 fetch
                        accRes_d = {31'h0000_0000, map_q[ei].valid &&
                            ((acc_q[0] && map_q[ei].rd) || (acc_q[1] && map_q[ei].wr) ||
                             (acc_q[2] && map_q[ei].ex))};
                        phase_d = 3'h0;
                    end
                    default: ;
                endcase
            end
            3'h2: begin
                phase_d = 3'h0;
                // version page may not hold its own version
                slotAddrOk = !(map_q[ei].ptype == PT_VERSION &&
                    argSlot_q[SW-1:$clog2(`EPT_VA_SLOTS)] ==
                    argIdx_q[SW-$clog2(`EPT_VA_SLOTS)-1:0]);
                case (cmd_q)
                    CMD_EVICT: begin
                        if (map_q[ei].valid && vaRd == `EPT_ZERO64 && slotAddrOk) begin
                            vaWr = 1'b1;
                            vaWrData = verCnt_q;
                            savedVer_d[ei] = verCnt_q;
                            verCnt_d = verCnt_q + 64'h0000_0000_0000_0001;
                            map_d[ei].valid = 1'b0;
                            result_d = 32'h0000_0000;
                        end else begin
                            result_d = 32'h0000_0001;
                        end
                    end
                    CMD_RELOAD: begin
                        if (!map_q[ei].valid && vaRd != `EPT_ZERO64 &&
                            vaRd == savedVer_q[ei]) begin
                            vaWr = 1'b1;
                            map_d[ei].valid = 1'b1;
                            result_d = 32'h0000_0000;
                        end else begin
                            result_d = 32'h0000_0001;
                        end
                    end
                    default: ;
                endcase
            end
            default: phase_d = 3'h0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                map_q[i] <= '0;
                savedVer_q[i] <= `EPT_ZERO64;
            end
            verCnt_q <= `EPT_VER_RESET;
            {argIdx_q, argSlot_q, argAddr_q, argOwner_q} <= '0;
            argFlags_q <= 32'h0000_0000;
            result_q <= 32'h0000_0000;
            acc_q <= 32'h0000_0000;
            accRes_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            virt_q <= 1'b0;
            info_q <= '0;
            phase_q <= 3'h0;
            cmd_q <= CMD_NONE;
            rdPend_q <= 1'b0;
        end else begin
            map_q <= map_d;
            savedVer_q <= savedVer_d;
            verCnt_q <= verCnt_d;
            {argIdx_q, argSlot_q, argAddr_q, argOwner_q} <=
                {argIdx_d, argSlot_d, argAddr_d, argOwner_d};
            rdPend_q <= rdPend_d;
            argFlags_q <= argFlags_d;
            result_q <= result_d;
            acc_q <= acc_d;
            accRes_q <= accRes_d;
            rdata_q <= rdata_d;
            virt_q <= virt_d;
            info_q <= info_d;
            phase_q <= phase_d;
            cmd_q <= cmd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_slot_on_evict: assert property (@(posedge ref_clk) disable iff (rst)
        (phase_q == 3'h2 && cmd_q == CMD_EVICT && vaWr) |-> vaWrData != `EPT_ZERO64)
        else $error("evict wrote empty version");
    a_reload_clears: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_q == CMD_RELOAD && vaWr) |-> vaWrData == `EPT_ZERO64 ##1 result_q == 32'h0)
        else $error("reload did not clear slot");
    // refused reload: failure reported, counter and entry valid bit untouched
    sequence s_reload_refused;
        result_q == 32'h1 && $stable(verCnt_q) && $stable(map_q[ei].valid);
    endsequence
    a_reload_fail: assert property (@(posedge ref_clk) disable iff (rst)
        (phase_q == 3'h2 && cmd_q == CMD_RELOAD && vaRd == `EPT_ZERO64) |-> !vaWr ##1
        s_reload_refused)
        else $error("bad reload changed state");
    a_access_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (phase_q == 3'h1 && cmd_q == CMD_NONE && !map_q[ei].valid) |=> accRes_q == 32'h0)
        else $error("access granted to invalid page");
    a_status_vchild: assert property (@(posedge ref_clk) disable iff (rst)
        info_q.status[63:1] == 63'h0)
        else $error("virtual child or reserved status set");
    a_status_child: assert property (@(posedge ref_clk) disable iff (rst)
        (phase_q == 3'h1 && cmd_q == CMD_INFO && map_q[ei].ptype != PT_CONTROL)
        |=> !info_q.status[0])
        else $error("child bit on non-control page");
    a_flags_type: assert property (@(posedge ref_clk) disable iff (rst)
        (phase_q == 3'h1 && cmd_q == CMD_INFO) |=> info_q.flags[15:8] == $past(map_q[ei].ptype)
        && info_q.flags[63] == $past(map_q[ei].blocked))
        else $error("flags type or blocked wrong");
    a_counter_unique: assert property (@(posedge ref_clk) disable iff (rst)
        vaWr && cmd_q == CMD_EVICT |=> verCnt_q == $past(verCnt_q) + 64'h1)
        else $error("version counter not advanced");
endmodule

// file: tb/ept_sw_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ept_sw_model (
    input wire logic ref_clk,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one bus cycle, held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic rw, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= rw;
        avs_write <= !rw;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released data no longer shows the last value
        avs_writedata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, d, 4'hF);
    endtask
    task automatic wrBe(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        xfer(1'b0, a, d, be);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b1, a, 32'h0000_0000, 4'hF);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // slot is a global index page*512+slot, so every page is 4K aligned
    task automatic op(input logic [31:0] c, input logic [31:0] idx, input logic [31:0] slot);
        wr(8'h04, idx);
        wr(8'h08, slot);
        wr(8'h00, c);
    endtask
endmodule

// file: tb/ept_page_tracking_tb_top.sv
`timescale 1ns/100ps
`include "ept_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module ept_page_tracking_tb_top
    import ept_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] expQ[$];
    logic [31:0] fl[0:7];
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'hea86;

    always #5 ref_clk = ~ref_clk;

    ept_sw_model sw (
        .ref_clk(ref_clk),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest)
    );
    ept_page_tracking #(.ENTRIES(16), .PAGES(4)) uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // note the expected word, then read it
    task automatic ex(input logic [7:0] a, input logic [31:0] v);
        expQ.push_back(v);
        sw.rd(a);
    endtask
    task automatic cmd(input logic [31:0] c, input logic [31:0] idx, input logic [31:0] slot,
                       input logic [31:0] res);
        sw.op(c, idx, slot);
        ex(`EPT_REG_RESULT, res);
    endtask
    task automatic access(input int i, input int k);
        sw.wr(`EPT_REG_ARG_IDX, 32'(i));
        sw.wr(`EPT_REG_ACC, 32'h0000_0001 << k);
        sw.wr(`EPT_REG_CMD, 32'(CMD_NONE));
    endtask
    task automatic info(input int i, input logic [31:0] st);
        sw.op(32'(CMD_INFO), 32'(i), 32'h0000_0000);
        // only the status word is read here; the first info loop reads the flags and parent words
        ex(`EPT_REG_INFO_ST, st);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // oldest note against the data standing at the accepting edge
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (expQ.size() == 0) begin
                miscompares++;
            end else begin
                check(expQ.pop_front(), avs_readdata);
            end
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        ex(`EPT_REG_RESULT, 32'h0000_0000);
        sw.wr(8'h3C, 32'hFFFF_FFFF);
        ex(8'h3C, 32'h0000_0000);
        sw.wr(`EPT_REG_ARG_ADDR, 32'h1234_5678);
        sw.wrBe(`EPT_REG_ARG_ADDR, 32'hAABB_CCDD, 4'h5);
        ex(`EPT_REG_ARG_ADDR, 32'h12BB_56DD);
        // entries 1..6 belong to control page 0; entry 7 is a childless control page
        for (int i = 0; i < 8; i++) begin
            fl[i] = ($random(seed) & 32'h0000_003F) | (32'(i % 7) << 8);
            if (i == 7) fl[i] = fl[i] | 32'h8000_0000;
            sw.wr(`EPT_REG_ARG_ADDR, 32'h0000_1000 * 32'(i));
            sw.wr(`EPT_REG_ARG_OWNER, (i == 0 || i == 7) ? 32'h0000_0009 : 32'h0000_0000);
            sw.wr(`EPT_REG_ARG_FLAGS, fl[i]);
            cmd(32'(CMD_LOAD), 32'(i), 32'h0000_0000, 32'h0000_0000);
        end
        for (int i = 0; i < 8; i++) begin
            info(i, (i == 0) ? 32'h0000_0001 : 32'h0000_0000);
            ex(`EPT_REG_INFO_FL_LO, fl[i] & 32'h0000_FF3F);
            ex(`EPT_REG_INFO_FL_HI, fl[i] & 32'h8000_0000);
            ex(`EPT_REG_INFO_PAR, (i == 0 || i == 7) ? 32'h9 : 32'h0);
        end
        sw.wr(`EPT_REG_VIRT, 32'h0000_0001);
        info(7, 32'h0000_0001);
        info(1, 32'h0000_0000);
        sw.wr(`EPT_REG_VIRT, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            for (int k = 0; k < 3; k++) begin
                access(i, k);
                ex(`EPT_REG_ACC_RES, 32'(fl[i][k]));
            end
        end
        sw.wr(`EPT_REG_ACC, 32'h0000_0007);
        cmd(32'(CMD_EVICT), 32'h2, 32'h5, 32'h0);
        access(2, 0);
        ex(`EPT_REG_ACC_RES, 32'h0000_0000);
        cmd(32'(CMD_RELOAD), 32'h2, 32'h5, 32'h0);
        cmd(32'(CMD_RELOAD), 32'h2, 32'h5, 32'h1);
        cmd(32'(CMD_EVICT), 32'h3, 32'h0000_0601, 32'h1);
        cmd(32'(CMD_EVICT), 32'h3, 32'h0000_01FF, 32'h0);
        cmd(32'(CMD_EVICT), 32'h4, 32'h6, 32'h0);
        cmd(32'(CMD_EVICT), 32'h5, 32'h7, 32'h0);
        cmd(32'(CMD_RELOAD), 32'h4, 32'h7, 32'h1);
        cmd(32'(CMD_RELOAD), 32'h4, 32'h0000_03E8, 32'h1);
        cmd(32'(CMD_RELOAD), 32'h4, 32'h6, 32'h0);
        cmd(32'(CMD_RELOAD), 32'h5, 32'h7, 32'h0);
        cmd(32'(CMD_RELOAD), 32'h3, 32'h0000_01FF, 32'h0);
        cmd(32'(CMD_EVICT), 32'h6, 32'h0000_07FF, 32'h0);
        cmd(32'(CMD_RELOAD), 32'h6, 32'h0000_07FF, 32'h0);
        repeat (4) @(posedge ref_clk);
        complete_run();
    end
endmodule
